// [rtl/sfsp_pkg.sv]
// Constants shared by both ends of the host serial link.
// Assumes a single 10 MHz clock and both ends set to one baud rate.
// Overview of operation
// R01: Ready output low while receive space remains
// R02: Receive buffer 1 KiB, transmit buffer 512
// R03: Peer not ready: no new character starts
// R04: Peer ready again: queued data resumes
// R05: Host ready line low only when accepting
// R06: Send only while opposite ready line low
// R07: Both lines low means both directions ready
// R08: Flow control none ignores clear-to-send input
// R09: Association indicator low while associated
// R10: Status blink patterns per connection state
// R11: Air receive indicator pulses low on activity
// R12: Air transmit indicator pulses low on activity
// R13: Session flag high without TCP, low with
// R14: Driver enable high while transmitting character
// R15: Baud rates 1200 to 115200, same both ends
// R16: Start low, LSB first, stop high, idle high
package sfsp_pkg;
	localparam int CLK_HZ           = 10000000;
	localparam int BAUD_DEFAULT     = 115200;
	localparam int BAUD_MIN         = 1200;
	localparam int BAUD_MAX         = 115200;
	localparam int RX_BUF_BYTES     = 1024;
	localparam int TX_BUF_BYTES     = 512;
	localparam int DATA_BITS        = 8;
	localparam int BLINK_PERIOD_MS  = 1000;
	localparam int BLINK_TICKS      = CLK_HZ / 1000 * BLINK_PERIOD_MS;
	localparam int SLOW_HALF        = BLINK_TICKS / 2;
	localparam int QUAD_HALF        = BLINK_TICKS / 8;
	localparam int FAST_HALF        = BLINK_TICKS / 64;
	localparam int ACT_PULSE_MS     = 20;
	localparam int ACT_TICKS        = CLK_HZ / 1000 * ACT_PULSE_MS;
	localparam logic [1:0] ST_CONNECTED = 2'h0;
	localparam logic [1:0] ST_NO_CONN   = 2'h1;
	localparam logic [1:0] ST_NO_IP     = 2'h2;
	localparam logic [1:0] ST_UNINIT    = 2'h3;
endpackage : sfsp_pkg

// [rtl/sfsp_link_if.sv]
// Host serial link between converter end and host end.
// Assumes both ends on one clock; the bench instantiates and joins them.
`timescale 1ns/1ps
interface sfsp_link_if;
	logic dev_to_host;
	logic host_to_dev;
	logic dev_ready_n;
	logic host_ready_n;
	modport dev  (output dev_to_host, output dev_ready_n, input host_to_dev, input host_ready_n);
	modport host (input dev_to_host, input dev_ready_n, output host_to_dev, output host_ready_n);
endinterface : sfsp_link_if

// [rtl/sfsp_dev.sv]
// Converter end: buffered UART with RTS/CTS and status indicators.
// Assumes synchronous inputs on CLK and a peer at the same baud rate.
`timescale 1ns/1ps
module sfsp_dev #(
	parameter int BAUD        = sfsp_pkg::BAUD_DEFAULT,
	parameter int RX_DEPTH    = sfsp_pkg::RX_BUF_BYTES,
	parameter int TX_DEPTH    = sfsp_pkg::TX_BUF_BYTES,
	parameter int BLINK_TICKS = sfsp_pkg::BLINK_TICKS,
	parameter int ACT_TICKS   = sfsp_pkg::ACT_TICKS
) (
	// Clock and reset
	input  wire logic       CLK,
	input  wire logic       RST,
	// Host link
	sfsp_link_if.dev        LINK,
	// Configuration
	input  wire logic       FLOW_EN,
	// Network side user data
	input  wire logic [7:0] TX_DATA,
	input  wire logic       TX_VALID,
	output logic            TX_READY,
	output logic [7:0]      RX_DATA,
	output logic            RX_VALID,
	input  wire logic       RX_READY,
	// Network status
	input  wire logic       ASSOCIATED,
	input  wire logic [1:0] CONN_STATE,
	input  wire logic       AIR_RX_EVENT,
	input  wire logic       AIR_TX_EVENT,
	// Indicators
	output logic            WIRELESS_ASSOC_IND,
	output logic            CONN_STATE_IND,
	output logic            AIR_RX_ACTIVITY_IND,
	output logic            AIR_TX_ACTIVITY_IND,
	output logic            TCP_SESSION_FLAG_N,
	output logic            LINE_DRIVER_ENABLE,
	output logic            LINE_DRIVER_ENABLE_OE
);
	localparam int BDIV  = sfsp_pkg::CLK_HZ / BAUD; // [R15]
	localparam int RXAW  = $clog2(RX_DEPTH);
	localparam int TXAW  = $clog2(TX_DEPTH);
	localparam int BLW   = $clog2(BLINK_TICKS + 1);
	localparam int ACW   = $clog2(ACT_TICKS + 1);
	localparam int SLOWH = BLINK_TICKS / 2;
	localparam int QUADH = BLINK_TICKS / 8;
	localparam int FASTH = BLINK_TICKS / 64;

	typedef enum logic [2:0] {T_IDLE = 3'h1, T_SHIFT = 3'h2, T_STOP = 3'h4} sfsp_tst_t;
	typedef enum logic [2:0] {R_IDLE = 3'h1, R_SHIFT = 3'h2, R_STOP = 3'h4} sfsp_rst_t;

	typedef struct packed {
		sfsp_tst_t       tst;
		logic [15:0]     tdiv;
		logic [3:0]      tbit;
		logic [9:0]      tsh;
		logic            txo;
		logic            de;
		logic [TXAW:0]   tcnt;
		logic [TXAW-1:0] twp;
		logic [TXAW-1:0] trp;
		sfsp_rst_t       rst;
		logic [15:0]     rdiv;
		logic [3:0]      rbit;
		logic [7:0]      rsh;
		logic [RXAW:0]   rcnt;
		logic [RXAW-1:0] rwp;
		logic [RXAW-1:0] rrp;
		logic            rts_n;
		logic [7:0]      rxd;
		logic            rxv;
		logic            txr;
		logic [BLW-1:0]  blk;
		logic            sts;
		logic            lnk;
		logic [ACW-1:0]  arc;
		logic [ACW-1:0]  atc;
		logic            ari;
		logic            ati;
		logic            tcpf;
	} sfsp_dev_t;

	sfsp_dev_t s_reg, s_next;
	logic [7:0] txmem [TX_DEPTH];
	logic [7:0] rxmem [RX_DEPTH];
	logic tx_push, rx_push, rx_pop, tx_pop, peer_ok;
	logic [BLW-1:0] half;

	function automatic logic [BLW-1:0] blink_half(input logic [1:0] st);
		if (st == sfsp_pkg::ST_NO_CONN) begin
			return BLW'(SLOWH);
		end else if (st == sfsp_pkg::ST_NO_IP) begin
			return BLW'(QUADH);
		end else begin
			return BLW'(FASTH);
		end
	endfunction : blink_half

	always_comb begin
		s_next  = s_reg;
		peer_ok = !FLOW_EN || !LINK.host_ready_n; // [R03] [R06] [R08]
		tx_push = TX_VALID && s_reg.txr;
		tx_pop  = 1'b0;
		rx_push = 1'b0;
		rx_pop  = s_reg.rxv && RX_READY;
		half    = blink_half(CONN_STATE);
		// Transmit toward host
		case (s_reg.tst)
			T_IDLE: begin
				s_next.de = 1'b0;
				if (s_reg.tcnt != '0 && peer_ok) begin // [R04] [R07]
					tx_pop      = 1'b1;
					s_next.tsh  = {1'b1, txmem[s_reg.trp], 1'b0}; // [R16]
					s_next.tst  = T_SHIFT;
					s_next.tdiv = '0;
					s_next.tbit = '0;
					s_next.de   = 1'b1; // [R14]
					s_next.trp  = s_reg.trp + 1'b1;
				end
			end
			T_SHIFT: begin
				s_next.txo = s_reg.tsh[0];
				if (s_reg.tdiv == 16'(BDIV - 1)) begin
					s_next.tdiv = '0;
					s_next.tsh  = {1'b1, s_reg.tsh[9:1]};
					s_next.tbit = s_reg.tbit + 4'h1;
					if (s_reg.tbit == 4'h9) begin
						s_next.tst = T_STOP;
					end
				end else begin
					s_next.tdiv = s_reg.tdiv + 16'h1;
				end
			end
			T_STOP: begin
				s_next.txo = 1'b1;
				s_next.tst = T_IDLE;
			end
			default: s_next.tst = T_IDLE;
		endcase
		if (tx_push) begin
			s_next.twp = s_reg.twp + 1'b1;
		end
		s_next.tcnt = s_reg.tcnt + (TXAW+1)'(tx_push) - (TXAW+1)'(tx_pop); // [R02]
		s_next.txr  = (s_next.tcnt < (TXAW+1)'(TX_DEPTH));
		// Receive from host
		case (s_reg.rst)
			R_IDLE: begin
				if (!LINK.host_to_dev) begin // [R16]
					s_next.rst  = R_SHIFT;
					s_next.rdiv = 16'(BDIV / 2);
					s_next.rbit = '0;
				end
			end
			R_SHIFT: begin
				if (s_reg.rdiv == 16'(BDIV - 1)) begin
					s_next.rdiv = '0;
					s_next.rbit = s_reg.rbit + 4'h1;
					s_next.rsh  = {LINK.host_to_dev, s_reg.rsh[7:1]};
					// First sample is the start bit; it shifts out
					if (s_reg.rbit == 4'h8) begin
						s_next.rst = R_STOP;
					end
				end else begin
					s_next.rdiv = s_reg.rdiv + 16'h1;
				end
			end
			R_STOP: begin
				if (s_reg.rdiv == 16'(BDIV - 1)) begin
					s_next.rst = R_IDLE;
					rx_push    = LINK.host_to_dev && (s_reg.rcnt < (RXAW+1)'(RX_DEPTH));
				end else begin
					s_next.rdiv = s_reg.rdiv + 16'h1;
				end
			end
			default: s_next.rst = R_IDLE;
		endcase
		if (rx_push) begin
			s_next.rwp = s_reg.rwp + 1'b1;
		end
		if (!s_reg.rxv && s_reg.rcnt != '0) begin
			s_next.rxd = rxmem[s_reg.rrp];
			s_next.rxv = 1'b1;
			s_next.rrp = s_reg.rrp + 1'b1;
		end else if (rx_pop) begin
			s_next.rxv = 1'b0;
		end
		s_next.rcnt = s_reg.rcnt + (RXAW+1)'(rx_push)
			- (RXAW+1)'(!s_reg.rxv && s_reg.rcnt != '0); // [R02]
		s_next.rts_n = (s_next.rcnt >= (RXAW+1)'(RX_DEPTH)); // [R01]
		// Indicators
		s_next.lnk  = !ASSOCIATED; // [R09]
		s_next.tcpf = (CONN_STATE != sfsp_pkg::ST_CONNECTED); // [R13]
		if (CONN_STATE == sfsp_pkg::ST_CONNECTED) begin
			s_next.sts = 1'b0; // [R10]
			s_next.blk = '0;
		end else if (s_reg.blk >= half - 1'b1) begin
			s_next.blk = '0;
			s_next.sts = !s_reg.sts; // [R10]
		end else begin
			s_next.blk = s_reg.blk + 1'b1;
		end
		s_next.arc = AIR_RX_EVENT ? ACW'(ACT_TICKS) : (s_reg.arc != '0 ? s_reg.arc - 1'b1 : '0);
		s_next.atc = AIR_TX_EVENT ? ACW'(ACT_TICKS) : (s_reg.atc != '0 ? s_reg.atc - 1'b1 : '0);
		s_next.ari = (s_next.arc == '0); // [R11]
		s_next.ati = (s_next.atc == '0); // [R12]
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			s_reg      <= '0;
			s_reg.tst  <= T_IDLE;
			s_reg.rst  <= R_IDLE;
			s_reg.txo  <= 1'b1;
			s_reg.txr  <= 1'b1;
			s_reg.lnk  <= 1'b1;
			s_reg.sts  <= 1'b1;
			s_reg.ari  <= 1'b1;
			s_reg.ati  <= 1'b1;
			s_reg.tcpf <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	always_ff @(posedge CLK) begin
		if (tx_push) begin
			txmem[s_reg.twp] <= TX_DATA;
		end
		if (rx_push) begin
			rxmem[s_reg.rwp] <= s_reg.rsh;
		end
	end

	assign LINK.dev_to_host     = s_reg.txo;
	assign LINK.dev_ready_n     = s_reg.rts_n;
	assign TX_READY             = s_reg.txr;
	assign RX_DATA              = s_reg.rxd;
	assign RX_VALID             = s_reg.rxv;
	assign WIRELESS_ASSOC_IND   = s_reg.lnk;
	assign CONN_STATE_IND       = s_reg.sts;
	assign AIR_RX_ACTIVITY_IND  = s_reg.ari;
	assign AIR_TX_ACTIVITY_IND  = s_reg.ati;
	assign TCP_SESSION_FLAG_N   = s_reg.tcpf;
	assign LINE_DRIVER_ENABLE   = s_reg.de;
	assign LINE_DRIVER_ENABLE_OE = 1'b1;
endmodule : sfsp_dev

// [rtl/sfsp_host.sv]
// Host end: single-byte UART with RTS/CTS toward the converter.
// Assumes synchronous inputs on CLK and the same baud rate as the converter.
`timescale 1ns/1ps
module sfsp_host #(
	parameter int BAUD = sfsp_pkg::BAUD_DEFAULT
) (
	// Clock and reset
	input  wire logic       CLK,
	input  wire logic       RST,
	// Host link
	sfsp_link_if.host       LINK,
	// Configuration
	input  wire logic       FLOW_EN,
	input  wire logic       HOLD_OFF,
	// User side
	input  wire logic [7:0] TX_DATA,
	input  wire logic       TX_VALID,
	output logic            TX_READY,
	output logic [7:0]      RX_DATA,
	output logic            RX_VALID
);
	localparam int BDIV = sfsp_pkg::CLK_HZ / BAUD; // [R15]

	typedef enum logic [2:0] {H_IDLE = 3'h1, H_SHIFT = 3'h2, H_STOP = 3'h4} sfsp_hst_t;

	typedef struct packed {
		sfsp_hst_t   tst;
		logic [15:0] tdiv;
		logic [3:0]  tbit;
		logic [9:0]  tsh;
		logic        txo;
		logic        txr;
		sfsp_hst_t   rst;
		logic [15:0] rdiv;
		logic [3:0]  rbit;
		logic [7:0]  rsh;
		logic [7:0]  rxd;
		logic        rxv;
		logic        rts_n;
	} sfsp_host_t;

	sfsp_host_t s_reg, s_next;

	always_comb begin
		s_next       = s_reg;
		s_next.rxv   = 1'b0;
		s_next.rts_n = HOLD_OFF; // [R05]
		case (s_reg.tst)
			H_IDLE: begin
				s_next.txr = !FLOW_EN || !LINK.dev_ready_n; // [R06]
				if (TX_VALID && s_reg.txr && (!FLOW_EN || !LINK.dev_ready_n)) begin // [R06] [R08]
					s_next.tsh  = {1'b1, TX_DATA, 1'b0}; // [R16]
					s_next.tst  = H_SHIFT;
					s_next.tdiv = '0;
					s_next.tbit = '0;
					s_next.txr  = 1'b0;
				end
			end
			H_SHIFT: begin
				s_next.txo = s_reg.tsh[0];
				if (s_reg.tdiv == 16'(BDIV - 1)) begin
					s_next.tdiv = '0;
					s_next.tsh  = {1'b1, s_reg.tsh[9:1]};
					s_next.tbit = s_reg.tbit + 4'h1;
					if (s_reg.tbit == 4'h9) begin
						s_next.tst = H_STOP;
					end
				end else begin
					s_next.tdiv = s_reg.tdiv + 16'h1;
				end
			end
			H_STOP: begin
				s_next.txo = 1'b1;
				s_next.tst = H_IDLE;
			end
			default: s_next.tst = H_IDLE;
		endcase
		case (s_reg.rst)
			H_IDLE: begin
				if (!LINK.dev_to_host) begin // [R16]
					s_next.rst  = H_SHIFT;
					s_next.rdiv = 16'(BDIV / 2);
					s_next.rbit = '0;
				end
			end
			H_SHIFT: begin
				if (s_reg.rdiv == 16'(BDIV - 1)) begin
					s_next.rdiv = '0;
					s_next.rbit = s_reg.rbit + 4'h1;
					s_next.rsh  = {LINK.dev_to_host, s_reg.rsh[7:1]};
					// First sample is the start bit; it shifts out
					if (s_reg.rbit == 4'h8) begin
						s_next.rst = H_STOP;
					end
				end else begin
					s_next.rdiv = s_reg.rdiv + 16'h1;
				end
			end
			H_STOP: begin
				if (s_reg.rdiv == 16'(BDIV - 1)) begin
					s_next.rst = H_IDLE;
					s_next.rxd = s_reg.rsh;
					s_next.rxv = LINK.dev_to_host;
				end else begin
					s_next.rdiv = s_reg.rdiv + 16'h1;
				end
			end
			default: s_next.rst = H_IDLE;
		endcase
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			s_reg     <= '0;
			s_reg.tst <= H_IDLE;
			s_reg.rst <= H_IDLE;
			s_reg.txo <= 1'b1;
			s_reg.txr <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	assign LINK.host_to_dev  = s_reg.txo;
	assign LINK.host_ready_n = s_reg.rts_n; // [R07]
	assign TX_READY          = s_reg.txr;
	assign RX_DATA           = s_reg.rxd;
	assign RX_VALID          = s_reg.rxv;
endmodule : sfsp_host

// [dv/sfsp_link_sva.sv]
// Checker: character framing and flow control on the host serial wires.
// Assumes one clock, BDIV cycles a bit at both ends, flow control on.
`timescale 1ns/1ps
module sfsp_link_sva #(
	parameter int BDIV = 10
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// Link wires
	input wire logic dev_to_host,
	input wire logic host_to_dev,
	input wire logic dev_ready_n,
	input wire logic host_ready_n
);
	localparam int STOP = 9 * BDIV;
	localparam int LAST = 9 * BDIV + 5;
	logic [7:0] d_cnt;
	logic [7:0] h_cnt;
	logic       d_prev;
	logic       h_prev;
	logic       d_st;
	logic       h_st;
	logic       d_hold;
	logic       h_hold;
	// Position within each character, counted from its start edge
	assign d_st   = !dev_to_host && d_prev && d_cnt == 8'h00;
	assign h_st   = !host_to_dev && h_prev && h_cnt == 8'h00;
	assign d_hold = d_cnt != 8'h00 && d_cnt % 8'(BDIV) != 8'h00;
	assign h_hold = h_cnt != 8'h00 && h_cnt % 8'(BDIV) != 8'h00;
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			d_cnt  <= 8'h00;
			h_cnt  <= 8'h00;
			d_prev <= 1'b1;
			h_prev <= 1'b1;
		end else begin
			d_prev <= dev_to_host;
			h_prev <= host_to_dev;
			d_cnt  <= d_st ? 8'h01 : (d_cnt != 8'h00 && d_cnt < 8'(LAST)) ? d_cnt + 8'h01 : 8'h00;
			h_cnt  <= h_st ? 8'h01 : (h_cnt != 8'h00 && h_cnt < 8'(LAST)) ? h_cnt + 8'h01 : 8'h00;
		end
	end
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);
	sequence s_dev_start;
		d_st;
	endsequence
	sequence s_host_start;
		h_st;
	endsequence
	sequence s_link_idle;
		(dev_to_host && host_to_dev && !dev_ready_n && !host_ready_n) [*3];
	endsequence
	a_dev_start_gate: assert property (
		s_dev_start |-> !$past(host_ready_n) || !$past(host_ready_n, 2))
		else $error("device started while host not ready");
	a_host_start_gate: assert property (
		s_host_start |-> !$past(dev_ready_n) || !$past(dev_ready_n, 2))
		else $error("host started while device full");
	a_dev_start_bit: assert property (
		s_dev_start |-> !dev_to_host [*8])
		else $error("device start bit too short");
	a_dev_bit_hold: assert property (
		d_hold |-> $stable(dev_to_host))
		else $error("device line moved inside a bit");
	a_host_bit_hold: assert property (
		h_hold |-> $stable(host_to_dev))
		else $error("host line moved inside a bit");
	a_dev_stop_high: assert property (
		d_cnt >= 8'(STOP) |-> dev_to_host)
		else $error("device stop bit low");
	a_host_stop_high: assert property (
		h_cnt >= 8'(STOP) |-> host_to_dev)
		else $error("host stop bit low");
	a_reset_idle: assert property (
		$fell(RST) |-> s_link_idle)
		else $error("link not idle and ready after reset");
endmodule : sfsp_link_sva

// [dv/serial_flow_status_port_tb.sv]
// Bench: converter end and host end on one link, plus a converter end
// with flow control off facing a host held not ready. One clock.
`timescale 1ns/1ps
module serial_flow_status_port_tb;
	localparam int BAUD_TB = 1000000;
	localparam int BDIV    = sfsp_pkg::CLK_HZ / BAUD_TB;
	localparam int BDIV2   = sfsp_pkg::CLK_HZ / sfsp_pkg::BAUD_MAX;
	localparam int RXD_TB  = 4;
	localparam int BLK_TB  = 640;
	localparam int ACT_TB  = 8;
	logic        clk, rst, hold_off, assoc, air_rx, air_tx, d2_valid, lde2, flow_en, lde_oe;
	logic        d_tx_valid, d_tx_ready, d_rx_valid, d_rx_ready, h_tx_valid, h_tx_ready;
	logic        h_rx_valid, assoc_ind, conn_ind, rx_ind, tx_ind, flag_n, lde;
	logic [1:0]  conn;
	logic [7:0]  d_tx_data, d_rx_data, h_tx_data, h_rx_data, d2_data;
	logic [7:0]  q_h[$];
	logic [7:0]  q_d[$];
	int          miscompares, tests_run;
	sfsp_link_if link();
	sfsp_link_if link2();
	assign link2.host_to_dev  = 1'b1;
	assign link2.host_ready_n = 1'b1;
	sfsp_dev #(.BAUD(BAUD_TB), .RX_DEPTH(RXD_TB), .BLINK_TICKS(BLK_TB), .ACT_TICKS(ACT_TB))
	u_sfsp_dev (
		.CLK(clk), .RST(rst), .LINK(link), .FLOW_EN(flow_en), .TX_DATA(d_tx_data),
		.TX_VALID(d_tx_valid), .TX_READY(d_tx_ready), .RX_DATA(d_rx_data), .RX_VALID(d_rx_valid),
		.RX_READY(d_rx_ready), .ASSOCIATED(assoc), .CONN_STATE(conn), .AIR_RX_EVENT(air_rx),
		.AIR_TX_EVENT(air_tx), .WIRELESS_ASSOC_IND(assoc_ind), .CONN_STATE_IND(conn_ind),
		.AIR_RX_ACTIVITY_IND(rx_ind), .AIR_TX_ACTIVITY_IND(tx_ind), .TCP_SESSION_FLAG_N(flag_n),
		.LINE_DRIVER_ENABLE(lde), .LINE_DRIVER_ENABLE_OE(lde_oe));
	sfsp_dev #(.BAUD(sfsp_pkg::BAUD_MAX), .RX_DEPTH(RXD_TB), .BLINK_TICKS(BLK_TB),
		.ACT_TICKS(ACT_TB)) u_sfsp_dev_2 (
		.CLK(clk), .RST(rst), .LINK(link2), .FLOW_EN(!flow_en), .TX_DATA(d2_data),
		.TX_VALID(d2_valid), .TX_READY(), .RX_DATA(), .RX_VALID(), .RX_READY(d_rx_ready),
		.ASSOCIATED(assoc), .CONN_STATE(conn), .AIR_RX_EVENT(air_rx), .AIR_TX_EVENT(air_tx),
		.WIRELESS_ASSOC_IND(), .CONN_STATE_IND(), .AIR_RX_ACTIVITY_IND(),
		.AIR_TX_ACTIVITY_IND(), .TCP_SESSION_FLAG_N(), .LINE_DRIVER_ENABLE(lde2),
		.LINE_DRIVER_ENABLE_OE());
	sfsp_host #(.BAUD(BAUD_TB)) u_sfsp_host (
		.CLK(clk), .RST(rst), .LINK(link), .FLOW_EN(flow_en), .HOLD_OFF(hold_off),
		.TX_DATA(h_tx_data), .TX_VALID(h_tx_valid), .TX_READY(h_tx_ready),
		.RX_DATA(h_rx_data), .RX_VALID(h_rx_valid));
	sfsp_link_sva #(.BDIV(BDIV)) u_sfsp_link_sva (
		.CLK(clk), .RST(rst), .dev_to_host(link.dev_to_host), .host_to_dev(link.host_to_dev),
		.dev_ready_n(link.dev_ready_n), .host_ready_n(link.host_ready_n));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic end_sim;
		if (miscompares == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic bound(input int n, input int lim);
		if (n >= lim) begin
			miscompares++;
			end_sim();
		end
	endtask : bound
	task automatic pop(ref logic [7:0] q[$], input logic [7:0] got);
		if (q.size() == 0) chk({8'h00, got}, 16'h0100);
		else chk({8'h00, got}, {8'h00, q.pop_front()});
	endtask : pop
	task automatic send(input logic dev, input logic [7:0] b);
		int n;
		n = 0;
		@(posedge clk);
		if (dev) begin
			d_tx_data  <= b;
			d_tx_valid <= 1'b1;
			q_h.push_back(b);
		end else begin
			h_tx_data  <= b;
			h_tx_valid <= 1'b1;
			q_d.push_back(b);
		end
		do begin
			@(posedge clk);
			n++;
		end while ((dev ? d_tx_ready : h_tx_ready) !== 1'b1 && n < 3000);
		bound(n, 3000);
		if (dev) d_tx_valid <= 1'b0;
		else h_tx_valid <= 1'b0;
	endtask : send
	task automatic wait_q;
		int n;
		for (n = 0; n < 20000 && (q_h.size() + q_d.size()) != 0; n++) @(posedge clk);
		bound(n, 20000);
	endtask : wait_q
	// Result watcher for both directions
	always @(posedge clk) begin
		if (h_rx_valid === 1'b1) pop(q_h, h_rx_data);
		if (d_rx_valid === 1'b1 && d_rx_ready === 1'b1) pop(q_d, d_rx_data);
	end
	initial begin
		int         n;
		logic       prev;
		logic [7:0] b;
		logic [7:0] got;
		logic [15:0] exp_tog [4];
		exp_tog = '{16'h0000, 16'h0002, 16'h0008, 16'h0040};
		{rst, d_rx_ready, flow_en} = 3'h7;
		{hold_off, assoc, air_rx, air_tx, d2_valid, d_tx_valid, h_tx_valid} = 7'h00;
		{conn, d_tx_data, h_tx_data, d2_data} = 26'h0;
		miscompares = 0;
		tests_run = 0;
		void'($urandom(32'h8752));
		repeat (20) @(posedge clk);
		chk({7'h0, assoc_ind, conn_ind, rx_ind, tx_ind, flag_n, lde, d_tx_ready,
			link.dev_ready_n, link.host_ready_n}, 16'h01f4);
		rst <= 1'b0;
		repeat (5) @(posedge clk);
		// Both directions at once
		fork
			repeat (4) send(1'b1, 8'($urandom));
			repeat (4) send(1'b0, 8'($urandom));
		join
		wait_q();
		// Host not ready: device holds its queue, then resumes
		hold_off <= 1'b1;
		repeat (3) @(posedge clk);
		repeat (2) send(1'b1, 8'($urandom));
		repeat (300) @(posedge clk);
		chk(16'(q_h.size()), 16'h0002);
		hold_off <= 1'b0;
		wait_q();
		// Receive space runs out at the fifth held byte
		d_rx_ready <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			send(1'b0, 8'($urandom));
			repeat (150) @(posedge clk);
			chk(16'(link.dev_ready_n), 16'(i == 4));
		end
		d_rx_ready <= 1'b1;
		wait_q();
		repeat (5) @(posedge clk);
		chk(16'(link.dev_ready_n), 16'h0000);
		// Flow control off: send despite a not-ready host; wire order and enable
		b = 8'($urandom);
		d2_data  <= b;
		d2_valid <= 1'b1;
		@(posedge clk);
		d2_valid <= 1'b0;
		for (n = 0; n < 50 && link2.dev_to_host !== 1'b0; n++) @(posedge clk);
		bound(n, 50);
		repeat (BDIV2 / 2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BDIV2) @(posedge clk);
			got[i] = link2.dev_to_host;
		end
		chk(16'(lde2), 16'h0001);
		chk(16'(lde_oe), 16'h0001);
		repeat (BDIV2) @(posedge clk);
		chk(16'(link2.dev_to_host), 16'h0001);
		chk(16'(got), 16'(b));
		repeat (2 * BDIV2) @(posedge clk);
		chk(16'(lde2), 16'h0000);
		// Association, session flag and blink rate per state
		for (int s = 0; s < 4; s++) begin
			conn  <= 2'(s);
			assoc <= s[0];
			repeat (20) @(posedge clk);
			chk(16'(flag_n), 16'(s != 0));
			chk(16'(assoc_ind), 16'(!s[0]));
			if (s == 0) chk(16'(conn_ind), 16'h0000);
			n = 0;
			prev = conn_ind;
			repeat (640) begin
				@(posedge clk);
				n += int'(conn_ind !== prev);
				prev = conn_ind;
			end
			chk(16'(n), exp_tog[s]);
		end
		// Air activity pulses
		for (int k = 0; k < 2; k++) begin
			air_rx <= (k == 0);
			air_tx <= (k == 1);
			@(posedge clk);
			air_rx <= 1'b0;
			air_tx <= 1'b0;
			repeat (3) @(posedge clk);
			chk({14'h0, rx_ind, tx_ind}, k ? 16'h0002 : 16'h0001);
			repeat (12) @(posedge clk);
			chk({14'h0, rx_ind, tx_ind}, 16'h0003);
		end
		end_sim();
	end
endmodule : serial_flow_status_port_tb
